// File: hw/sfw_pkg.sv
package sfw_pkg;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRAP = 8'h77;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CE1 = 8'h60;
  localparam logic [7:0] OP_CE2 = 8'hc7;
  localparam logic [7:0] OP_PROG = 8'h02;
  // ---------------------------------------------------------------
  // Frame lengths in whole bytes
  // ---------------------------------------------------------------
  localparam logic [10:0] LEN_SHORT = 11'h001;
  localparam logic [10:0] LEN_REGION = 11'h004;
  localparam logic [10:0] LEN_WRAP = 11'h005;
  localparam logic [10:0] LEN_MAX = 11'h7ff;
  // ---------------------------------------------------------------
  // Fields, regions, reset values
  // ---------------------------------------------------------------
  localparam int WRAP_LSB = 4;
  localparam logic [2:0] WRAP_RESET = 3'h1;
  localparam int PAGE_BITS = 8;
  localparam int SECTOR_BITS = 12;
  localparam int HALF_BITS = 15;
  localparam int BLOCK_BITS = 16;
  localparam int BLOCK_IDX_LSB = 16;
  localparam int BLOCK_COUNT = 16;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PAGE_ERASE_TIME_US = 1000;
  localparam int SECTOR_ERASE_TIME_US = 2000;
  localparam int HALF_BLOCK_ERASE_TIME_US = 4000;
  localparam int BLOCK_ERASE_TIME_US = 8000;
  localparam int CHIP_ERASE_TIME_US = 16000;
  localparam int PAGE_PROGRAM_TIME_US = 500;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {SFW_PAGE, SFW_SECTOR, SFW_HALF, SFW_BLOCK, SFW_CHIP, SFW_PROG} sfw_kind_t;
  typedef enum logic [1:0] {SFW_IDLE, SFW_STREAM, SFW_WAIT} sfw_state_t;
  typedef struct packed {
    logic we;
    logic erase;
    sfw_kind_t kind;
    logic [23:0] addr;
    logic [7:0] data;
  } sfw_array_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] wrap;
    logic [10:0] count;
    logic aligned;
  } sfw_frame_t;
endpackage

// File: hw/sfw_flash_seq.sv
// What this block does
// - Wrap setup: 77h, 24 dummy, 8 wrap bits
// - Wrap length codes 8/16/32/64 within page
// - Stored wrap applies to later quad reads
// - Wrap disable resets to 1, no wrap
// - 81h page erase, 20h sector erase
// - 52h half block, D8h block erase
// - Erase/program need write enable latch set
// - Region erase: opcode plus three address bytes
// - Region erase needs chip select at boundary
// - Chip select rise starts timed cycle
// - Progress flag high during cycle only
// - Write enable latch cleared during cycle
// - Protected regions are never erased, programmed
// - Chip erase: 60h/C7h, one byte only
// - Chip erase only with no protection
// - Program: 02h, address, data bytes
// - Program data wraps inside same page
// - Over 256 bytes: last 256 kept
// - Unsent page bytes stay untouched
// - Program needs chip select at byte boundary
module sfw_flash_seq #(
  parameter int PAGE_ERASE_CYCLES = sfw_pkg::PAGE_ERASE_TIME_US * sfw_pkg::CLK_MHZ,
  parameter int SECTOR_ERASE_CYCLES = sfw_pkg::SECTOR_ERASE_TIME_US * sfw_pkg::CLK_MHZ,
  parameter int HALF_BLOCK_ERASE_CYCLES = sfw_pkg::HALF_BLOCK_ERASE_TIME_US * sfw_pkg::CLK_MHZ,
  parameter int BLOCK_ERASE_CYCLES = sfw_pkg::BLOCK_ERASE_TIME_US * sfw_pkg::CLK_MHZ,
  parameter int CHIP_ERASE_CYCLES = sfw_pkg::CHIP_ERASE_TIME_US * sfw_pkg::CLK_MHZ,
  parameter int PAGE_PROGRAM_CYCLES = sfw_pkg::PAGE_PROGRAM_TIME_US * sfw_pkg::CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic block_protect_bit4,
  input wire logic block_protect_bit3,
  input wire logic block_protect_bit2,
  input wire logic block_protect_bit1,
  input wire logic block_protect_bit0,
  output logic write_in_progress_flag,
  output logic write_enable_latch,
  output logic wrap_disable_bit,
  output logic wrap_length_bit_high,
  output logic wrap_length_bit_low,
  output logic [5:0] wrap_mask,
  output sfw_pkg::sfw_array_t array_cmd
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [23:0] region_base(input sfw_pkg::sfw_kind_t kind, input logic [23:0] addr);
    logic [23:0] base;
    base = addr;
    case (kind)
      sfw_pkg::SFW_PAGE, sfw_pkg::SFW_PROG: base[sfw_pkg::PAGE_BITS-1:0] = '0;
      sfw_pkg::SFW_SECTOR: base[sfw_pkg::SECTOR_BITS-1:0] = '0;
      sfw_pkg::SFW_HALF: base[sfw_pkg::HALF_BITS-1:0] = '0;
      sfw_pkg::SFW_BLOCK: base[sfw_pkg::BLOCK_BITS-1:0] = '0;
      default: base = '0;
    endcase
    return base;
  endfunction
  // Upper blocks are protected; all five bits set or bit4 alone covers everything
  function automatic logic is_protected(input logic [23:0] addr, input logic [4:0] bp);
    logic [4:0] sum;
    sum = {1'b0, addr[sfw_pkg::BLOCK_IDX_LSB+3:sfw_pkg::BLOCK_IDX_LSB]} + {1'b0, bp[3:0]};
    return (bp != 5'h00) && (bp[4] || (sum >= 5'(sfw_pkg::BLOCK_COUNT)));
  endfunction
  function automatic logic [31:0] duration(input sfw_pkg::sfw_kind_t kind);
    case (kind)
      sfw_pkg::SFW_PAGE: return 32'(PAGE_ERASE_CYCLES);
      sfw_pkg::SFW_SECTOR: return 32'(SECTOR_ERASE_CYCLES);
      sfw_pkg::SFW_HALF: return 32'(HALF_BLOCK_ERASE_CYCLES);
      sfw_pkg::SFW_BLOCK: return 32'(BLOCK_ERASE_CYCLES);
      sfw_pkg::SFW_CHIP: return 32'(CHIP_ERASE_CYCLES);
      default: return 32'(PAGE_PROGRAM_CYCLES);
    endcase
  endfunction
  function automatic logic [5:0] wrap_span(input logic [1:0] len);
    logic [6:0] span;
    span = (7'h08 << len) - 7'h01;
    return span[5:0];
  endfunction

  logic [4:0] bp;
  assign bp = {block_protect_bit4, block_protect_bit3, block_protect_bit2, block_protect_bit1, block_protect_bit0};

  // ---------------------------------------------------------------
  // Link side, on the serial clock
  // ---------------------------------------------------------------
  // Counters clear while chip select is high; results survive the frame
  logic link_rst;
  logic [2:0] bit_cnt;
  logic [10:0] byte_cnt;
  logic [6:0] shift;
  logic [7:0] next_byte;
  logic byte_done;
  logic [10:0] next_count;
  sfw_pkg::sfw_frame_t frame;
  logic frame_tag;
  logic busy_meta;
  logic busy_link;
  logic [7:0] wptr;
  logic [7:0] pbuf [256];
  logic [255:0] pmask;
  logic data_byte;

  assign link_rst = rst | cs_n;
  assign next_byte = {shift, si};
  assign byte_done = (bit_cnt == 3'h7);
  assign next_count = (byte_done && byte_cnt != sfw_pkg::LEN_MAX) ? byte_cnt + 11'h001 : byte_cnt;
  // Buffer is frozen while a cycle may still be reading it
  assign data_byte = byte_done && byte_cnt >= sfw_pkg::LEN_REGION && frame.opcode == sfw_pkg::OP_PROG && !busy_link;

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 11'h000;
      shift <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= next_byte[6:0];
      byte_cnt <= next_count;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      frame <= '0;
    end else begin
      frame.count <= next_count;
      frame.aligned <= byte_done;
      if (byte_done) begin
        case (byte_cnt)
          11'h000: frame.opcode <= next_byte;
          11'h001: frame.addr[23:16] <= next_byte;
          11'h002: frame.addr[15:8] <= next_byte;
          11'h003: frame.addr[7:0] <= next_byte;
          11'h004: frame.wrap <= next_byte;
          default: ;
        endcase
      end
    end
  end

  // Toggles on a frame's first edge so an empty frame is not taken twice
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      frame_tag <= 1'b0;
    end else if (byte_cnt == 11'h000 && bit_cnt == 3'h0) begin
      frame_tag <= ~frame_tag;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      busy_meta <= 1'b0;
      busy_link <= 1'b0;
    end else begin
      busy_meta <= write_in_progress_flag;
      busy_link <= busy_meta;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      wptr <= 8'h00;
    end else if (byte_done && byte_cnt == 11'h003) begin
      wptr <= next_byte;
    end else if (data_byte) begin
      wptr <= wptr + 8'h01;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      pmask <= '0;
      for (int i = 0; i < 256; i++) begin
        pbuf[i] <= 8'h00;
      end
    end else if (data_byte) begin
      pbuf[wptr] <= next_byte;
      // First data byte starts a fresh mask
      pmask <= (byte_cnt == sfw_pkg::LEN_REGION ? 256'h0 : pmask) | (256'h1 << wptr);
    end
  end

  // ---------------------------------------------------------------
  // Chip select crossing
  // ---------------------------------------------------------------
  // Link results are read only at frame end, when the serial clock is idle
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic used_tag;
  logic frame_end;
  logic new_frame;

  assign frame_end = cs_sync & ~cs_prev;
  assign new_frame = frame_end && (frame_tag != used_tag);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      used_tag <= 1'b0;
    end else if (new_frame) begin
      used_tag <= frame_tag;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  sfw_pkg::sfw_state_t state;
  logic accept;
  logic cand;
  sfw_pkg::sfw_kind_t cand_kind;
  logic allowed;
  logic go;
  logic set_latch;
  logic clr_latch;
  logic set_wrap;

  assign accept = new_frame && frame.aligned && state == sfw_pkg::SFW_IDLE && !write_in_progress_flag;
  always_comb begin
    cand = frame.count == sfw_pkg::LEN_REGION;
    cand_kind = sfw_pkg::SFW_PAGE;
    case (frame.opcode)
      sfw_pkg::OP_PAGE_ERASE: cand_kind = sfw_pkg::SFW_PAGE;
      sfw_pkg::OP_SECTOR_ERASE: cand_kind = sfw_pkg::SFW_SECTOR;
      sfw_pkg::OP_HALF_ERASE: cand_kind = sfw_pkg::SFW_HALF;
      sfw_pkg::OP_BLOCK_ERASE: cand_kind = sfw_pkg::SFW_BLOCK;
      sfw_pkg::OP_CE1, sfw_pkg::OP_CE2: begin
        cand = frame.count == sfw_pkg::LEN_SHORT;
        cand_kind = sfw_pkg::SFW_CHIP;
      end
      sfw_pkg::OP_PROG: begin
        cand = frame.count > sfw_pkg::LEN_REGION;
        cand_kind = sfw_pkg::SFW_PROG;
      end
      default: cand = 1'b0;
    endcase
  end
  assign allowed = (cand_kind == sfw_pkg::SFW_CHIP) ? (bp == 5'h00) : !is_protected(frame.addr, bp);
  assign go = accept && cand && write_enable_latch && allowed;
  assign set_latch = accept && frame.opcode == sfw_pkg::OP_WREN && frame.count == sfw_pkg::LEN_SHORT;
  assign clr_latch = accept && frame.opcode == sfw_pkg::OP_WRDI && frame.count == sfw_pkg::LEN_SHORT;
  assign set_wrap = accept && frame.opcode == sfw_pkg::OP_WRAP && frame.count == sfw_pkg::LEN_WRAP;

  // ---------------------------------------------------------------
  // Write enable latch and wrap setting
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (set_latch) begin
      write_enable_latch <= 1'b1;
    end else if (go || clr_latch) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {wrap_length_bit_high, wrap_length_bit_low, wrap_disable_bit} <= sfw_pkg::WRAP_RESET;
      wrap_mask <= 6'h00;
    end else if (set_wrap) begin
      {wrap_length_bit_high, wrap_length_bit_low, wrap_disable_bit} <= frame.wrap[sfw_pkg::WRAP_LSB+2:sfw_pkg::WRAP_LSB];
      // Low read-address bits that wrap; zero means linear
      wrap_mask <= frame.wrap[sfw_pkg::WRAP_LSB] ? 6'h00 :
        wrap_span(frame.wrap[sfw_pkg::WRAP_LSB+2:sfw_pkg::WRAP_LSB+1]);
    end
  end

  // ---------------------------------------------------------------
  // Self-timed cycle
  // ---------------------------------------------------------------
  logic [31:0] timer;
  logic [7:0] idx;
  logic [23:0] base;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= sfw_pkg::SFW_IDLE;
      timer <= 32'h0;
      idx <= 8'h00;
      base <= 24'h000000;
    end else begin
      case (state)
        sfw_pkg::SFW_IDLE: begin
          if (go) begin
            timer <= duration(cand_kind) - 32'h1;
            base <= region_base(cand_kind, frame.addr);
            idx <= 8'h00;
            state <= (cand_kind == sfw_pkg::SFW_PROG) ? sfw_pkg::SFW_STREAM : sfw_pkg::SFW_WAIT;
          end
        end
        sfw_pkg::SFW_STREAM: begin
          if (timer != 32'h0) begin
            timer <= timer - 32'h1;
          end
          idx <= idx + 8'h01;
          if (idx == 8'hff) begin
            state <= sfw_pkg::SFW_WAIT;
          end
        end
        sfw_pkg::SFW_WAIT: begin
          if (timer == 32'h0) begin
            state <= sfw_pkg::SFW_IDLE;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        default: state <= sfw_pkg::SFW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_in_progress_flag <= 1'b0;
    end else if (go) begin
      write_in_progress_flag <= 1'b1;
    end else if (state == sfw_pkg::SFW_WAIT && timer == 32'h0) begin
      write_in_progress_flag <= 1'b0;
    end
  end

  // Erase is one command beat; program streams the whole page, masked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      array_cmd <= '0;
    end else begin
      array_cmd.we <= 1'b0;
      array_cmd.erase <= 1'b0;
      if (go && cand_kind != sfw_pkg::SFW_PROG) begin
        array_cmd.erase <= 1'b1;
        array_cmd.kind <= cand_kind;
        array_cmd.addr <= region_base(cand_kind, frame.addr);
        array_cmd.data <= 8'hff;
      end else if (state == sfw_pkg::SFW_STREAM) begin
        array_cmd.we <= pmask[idx];
        array_cmd.kind <= sfw_pkg::SFW_PROG;
        array_cmd.addr <= {base[23:8], idx};
        array_cmd.data <= pbuf[idx];
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_busy_start: assert property (go |=> write_in_progress_flag)
    else $error("progress flag not raised at cycle start");
  chk_latch_clear: assert property (go |=> !write_enable_latch)
    else $error("write enable latch not cleared");
  chk_busy_ignore: assert property (new_frame && write_in_progress_flag |-> !go && !set_latch)
    else $error("command taken while busy");
  chk_need_wel: assert property (frame_end && !write_enable_latch |-> !go)
    else $error("cycle started without write enable");
  chk_chip_prot: assert property (go && cand_kind == sfw_pkg::SFW_CHIP |-> bp == 5'h00)
    else $error("chip erase with protection set");
  chk_region_prot: assert property (go && cand_kind != sfw_pkg::SFW_CHIP |-> !is_protected(frame.addr, bp))
    else $error("protected region altered");
  chk_boundary: assert property (frame_end && !frame.aligned |=> !write_in_progress_flag || $past(write_in_progress_flag))
    else $error("misaligned frame started a cycle");
  chk_busy_hold: assert property ($rose(write_in_progress_flag) |-> write_in_progress_flag [*8])
    else $error("progress flag dropped early");
  chk_wrap_span: assert property (!wrap_disable_bit |-> wrap_mask == wrap_span({wrap_length_bit_high, wrap_length_bit_low}))
    else $error("wrap span mismatch");
  chk_wrap_off: assert property (wrap_disable_bit |-> wrap_mask == 6'h00)
    else $error("wrap active while disabled");
  chk_prog_page: assert property (array_cmd.we |-> array_cmd.addr[23:8] == base[23:8] && array_cmd.kind == sfw_pkg::SFW_PROG)
    else $error("program beat outside page");
  chk_erase_beat: assert property (go && cand_kind != sfw_pkg::SFW_PROG |=> array_cmd.erase ##1 !array_cmd.erase)
    else $error("erase beat not single");
  cov_erase: cover property (go && cand_kind == sfw_pkg::SFW_SECTOR);
  cov_prog: cover property (go && cand_kind == sfw_pkg::SFW_PROG ##[1:300] array_cmd.we);
  cov_wrap: cover property (set_wrap && !frame.wrap[sfw_pkg::WRAP_LSB]);
  cov_reject: cover property (new_frame && write_in_progress_flag);
endmodule // sfw_flash_seq

// File: verification/sfw_host.sv
module sfw_host (
  output logic sclk,
  output logic cs_n,
  output logic si
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] bytes [0:299];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // ---------------------------------------------------------------
  // One frame: whole bytes MSB first, then optional stray bits
  // ---------------------------------------------------------------
  // Serial clock idles low between frames, so mode 0 only
  task automatic frame(input int nbytes, input int stray);
    int b;
    #13;
    cs_n <= 1'b0;
    #20;
    for (b = 0; b < nbytes * 8 + stray; b++) begin
      si <= bytes[b / 8][7 - b % 8];
      #32 sclk <= 1'b1;
      #32 sclk <= 1'b0;
    end
    #20 cs_n <= 1'b1;
    // Released line must not keep looking valid
    si <= ~si;
    #100;
  endtask
endmodule // sfw_host

// File: verification/sfw_flash_seq_bench.sv
module sfw_flash_seq_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // Short durations keep the run small; program must exceed 256 beats
  localparam int DUR [6] = '{150, 160, 170, 180, 190, 400};
  localparam logic [7:0] OPS [6] = '{sfw_pkg::OP_PAGE_ERASE, sfw_pkg::OP_SECTOR_ERASE, sfw_pkg::OP_HALF_ERASE,
    sfw_pkg::OP_BLOCK_ERASE, sfw_pkg::OP_CE1, sfw_pkg::OP_CE2};
  localparam sfw_pkg::sfw_kind_t KINDS [6] = '{sfw_pkg::SFW_PAGE, sfw_pkg::SFW_SECTOR, sfw_pkg::SFW_HALF,
    sfw_pkg::SFW_BLOCK, sfw_pkg::SFW_CHIP, sfw_pkg::SFW_CHIP};
  localparam logic [23:0] BASES [6] = '{24'h0a5600, 24'h0a5000, 24'h0a0000, 24'h0a0000, 24'h0, 24'h0};
  logic clk;
  logic rst;
  logic sclk;
  logic cs_n;
  logic si;
  logic [4:0] bp;
  logic busy;
  logic latch;
  logic wdis;
  logic wlh;
  logic wll;
  logic [5:0] wrap_mask;
  sfw_pkg::sfw_array_t array_cmd;
  logic exp_we [256];
  logic [7:0] exp_d [256];
  int errors;
  int checked;
  int k;

  sfw_host i_sfw_host (.sclk(sclk), .cs_n(cs_n), .si(si));
  sfw_flash_seq #(
    .PAGE_ERASE_CYCLES(DUR[0]), .SECTOR_ERASE_CYCLES(DUR[1]), .HALF_BLOCK_ERASE_CYCLES(DUR[2]),
    .BLOCK_ERASE_CYCLES(DUR[3]), .CHIP_ERASE_CYCLES(DUR[4]), .PAGE_PROGRAM_CYCLES(DUR[5])
  ) i_sfw_flash_seq (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .block_protect_bit4(bp[4]), .block_protect_bit3(bp[3]), .block_protect_bit2(bp[2]),
    .block_protect_bit1(bp[1]), .block_protect_bit0(bp[0]),
    .write_in_progress_flag(busy), .write_enable_latch(latch), .wrap_disable_bit(wdis),
    .wrap_length_bit_high(wlh), .wrap_length_bit_low(wll), .wrap_mask(wrap_mask), .array_cmd(array_cmd)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n, input int stray);
    i_sfw_host.bytes[0] = op;
    i_sfw_host.bytes[1] = a[23:16];
    i_sfw_host.bytes[2] = a[15:8];
    i_sfw_host.bytes[3] = a[7:0];
    i_sfw_host.frame(n, stray);
  endtask

  task automatic quiet(input string what);
    logic seen;
    int i;
    seen = 1'b0;
    for (i = 0; i < 8; i++) begin
      tick();
      seen = seen | (busy !== 1'b0) | (array_cmd.erase !== 1'b0);
    end
    cmp(what, 0, seen);
  endtask

  task automatic go(input int dur, input sfw_pkg::sfw_kind_t kind, input logic [23:0] base, input bit prog);
    int i;
    int n;
    for (i = 0; i < 20000 && busy !== 1'b1; i++) tick();
    cmp("busy rise", 1, busy);
    if (busy !== 1'b1) close_out();
    n = 1;
    cmp("latch cleared", 0, latch);
    if (!prog) begin
      cmp("erase pulse", 1, array_cmd.erase);
      cmp("erase kind", kind, array_cmd.kind);
      cmp("erase base", base, array_cmd.addr);
      cmp("erase data", 8'hff, array_cmd.data);
      tick();
      n += (busy === 1'b1);
      cmp("erase single", 0, array_cmd.erase);
    end else begin
      for (i = 0; i < 256; i++) begin
        tick();
        n += (busy === 1'b1);
        cmp("beat addr", {base[23:8], i[7:0]}, array_cmd.addr);
        cmp("beat we", exp_we[i], array_cmd.we);
        if (exp_we[i]) cmp("beat data", exp_d[i], array_cmd.data);
      end
    end
    for (i = 0; i < 2000 && busy === 1'b1; i++) begin
      tick();
      n += (busy === 1'b1);
    end
    cmp("busy length", dur, n);
  endtask

  task automatic prog(input logic [23:0] a, input int n);
    int i;
    int off;
    for (i = 0; i < 256; i++) exp_we[i] = 1'b0;
    for (i = 0; i < n; i++) begin
      off = (a[7:0] + i) % 256;
      exp_we[off] = 1'b1;
      exp_d[off] = i[7:0] ^ {i[8], 7'h3c};
      i_sfw_host.bytes[4 + i] = i[7:0] ^ {i[8], 7'h3c};
    end
    cmd(sfw_pkg::OP_WREN, 24'h0, 1, 0);
    fork
      cmd(sfw_pkg::OP_PROG, a, 4 + n, 0);
      go(DUR[5], sfw_pkg::SFW_PROG, a, 1'b1);
    join
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    bp = 5'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) tick();
    cmp("reset wrap off", 1, wdis);
    cmp("reset mask", 0, wrap_mask);
    cmp("reset latch", 0, latch);
    cmp("reset length", 0, {wlh, wll});
    for (k = 0; k < 4; k++) begin
      i_sfw_host.bytes[4] = {1'b0, k[1:0], 5'h0a};
      cmd(sfw_pkg::OP_WRAP, 24'h123456, 5, 0);
      cmp("wrap on", 0, wdis);
      cmp("wrap len", k, {wlh, wll});
      cmp("wrap mask", (8 << k) - 1, wrap_mask);
    end
    i_sfw_host.bytes[4] = 8'h70;
    cmd(sfw_pkg::OP_WRAP, 24'h0, 5, 0);
    cmp("wrap back", 1, wdis);
    cmp("linear mask", 0, wrap_mask);
    cmd(sfw_pkg::OP_SECTOR_ERASE, 24'h0a5678, 4, 0);
    quiet("erase without latch");
    cmd(sfw_pkg::OP_WREN, 24'h0, 1, 0);
    cmd(sfw_pkg::OP_SECTOR_ERASE, 24'h0a5678, 4, 3);
    quiet("stray bits");
    cmd(sfw_pkg::OP_SECTOR_ERASE, 24'h0a5678, 5, 0);
    quiet("long erase");
    cmd(sfw_pkg::OP_CE1, 24'h0a5678, 2, 0);
    quiet("long chip erase");
    cmd(sfw_pkg::OP_PROG, 24'h0a5678, 5, 4);
    quiet("split data byte");
    @(posedge clk) bp <= 5'h10;
    cmd(sfw_pkg::OP_SECTOR_ERASE, 24'h0a5678, 4, 0);
    quiet("all protected");
    cmd(sfw_pkg::OP_CE2, 24'h0, 1, 0);
    quiet("chip all protected");
    @(posedge clk) bp <= 5'h01;
    cmd(sfw_pkg::OP_BLOCK_ERASE, 24'h0f1234, 4, 0);
    quiet("top block protected");
    cmd(sfw_pkg::OP_CE1, 24'h0, 1, 0);
    quiet("chip partly protected");
    cmp("latch kept", 1, latch);
    cmd(sfw_pkg::OP_WRDI, 24'h0, 1, 0);
    cmp("latch off", 0, latch);
    cmd(sfw_pkg::OP_PROG, 24'h0012fe, 7, 0);
    quiet("program without latch");
    prog(24'h0012fe, 3);
    prog(24'h003400, 258);
    @(posedge clk) bp <= 5'h00;
    for (k = 0; k < 6; k++) begin
      cmd(sfw_pkg::OP_WREN, 24'h0, 1, 0);
      cmp("latch set", 1, latch);
      fork
        begin
          cmd(OPS[k], 24'h0a5678, k < 4 ? 4 : 1, 0);
          cmd(sfw_pkg::OP_WREN, 24'h0, 1, 0);
        end
        go(DUR[k < 5 ? k : 4], KINDS[k], BASES[k], 1'b0);
      join
      cmp("wren while busy", 0, latch);
    end
    close_out();
  end
endmodule // sfw_flash_seq_bench
